//--- hdl/limit_timer_pkg.sv
`default_nettype none
package limit_timer_pkg;
	// ****************************************
	// Register map (byte addresses, word aligned)
	// ****************************************
	localparam logic [4:0] OFS_LIMIT_COUNT = 5'h00; // Counter value
	localparam logic [4:0] OFS_LIMIT_PERIOD = 5'h04; // Period value
	localparam logic [4:0] OFS_CTRL_REG0 = 5'h08; // Postscale, on, prescale
	localparam logic [4:0] OFS_CTRL_REG1 = 5'h0c; // Reset source and edge enables
	localparam logic [4:0] OFS_IRQ_FLAGS = 5'h10; // Match flag, write one to clear
	localparam logic [4:0] OFS_IRQ_ENABLES = 5'h14; // Match interrupt enable

	// ****************************************
	// Reset values and field layout
	// ****************************************
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] PERIOD_RESET = 8'hff;
	localparam int CTRL0_POST_LSB = 3; // Bits 6:3
	localparam int CTRL0_ON_BIT = 2;
	localparam int CTRL0_DIV_LSB = 0; // Bits 1:0
	localparam int CTRL1_SRC_LSB = 2; // Bits 4:2
	localparam int CTRL1_FALL_BIT = 1;
	localparam int CTRL1_RISE_BIT = 0;
	localparam int IRQ_MATCH_BIT = 0;

	// ****************************************
	// Timing
	// ****************************************
	localparam int OSC_PER_INSTR = 4; // Instruction clock is a quarter of the reference
	localparam logic [1:0] INSTR_LAST = 2'h3; // Last phase of the instruction divider
	localparam logic [3:0] PRE_LAST_DIV4 = 4'h3;
	localparam logic [3:0] PRE_LAST_DIV16 = 4'hf;

	// ****************************************
	// Encodings
	// ****************************************
	localparam logic [1:0] DIV_SEL_1 = 2'h0;
	localparam logic [1:0] DIV_SEL_4 = 2'h1;
	localparam logic [2:0] SRC_CAPCMP = 3'h0;
	localparam logic [2:0] SRC_CMP1 = 3'h1;
	localparam logic [2:0] SRC_CMP2 = 3'h2;
	localparam logic [2:0] SRC_GEN_FAULT = 3'h3;
	localparam logic [2:0] SRC_GEN_OUT0 = 3'h4;
	localparam logic [2:0] SRC_GEN_OUT1 = 3'h5;

	// First control register contents
	typedef struct packed {
		logic [3:0] postscale_sel;
		logic timer_on;
		logic [1:0] clk_div_sel;
	} ctrl_reg0_s;

	// Second control register contents
	typedef struct packed {
		logic [2:0] reset_source_sel;
		logic fall_reset_en;
		logic rise_reset_en;
	} ctrl_reg1_s;

	// Peripheral reset inputs
	typedef struct packed {
		logic gen_out1;
		logic gen_out0;
		logic gen_fault;
		logic comparator2_out;
		logic comparator1_out;
		logic capture_compare;
	} reset_src_s;
endpackage
`default_nettype wire

//--- hdl/hardware_limit_timer.sv
// Function
// - Count from instruction clock, quarter reference rate
// - Prescaler offers direct, divide four, sixteen
// - Assert limit match while count equals period; code asserts it only while also running
// - Match clears counter, advances postscaler once
// - Pulse to pulse takes (period+1)*4 cycles undivided
// - Counter and period registers fully read/write
// - Reset clears counter, period becomes all ones
// - Count write, first control register write, reset clear scalers
// - Control write leaves counter value unchanged
// - Postscaler overflow sets match interrupt flag
// - Interrupt forwarded only when enable set
// - Sixteen postscale ratios, one to sixteen
// - Three-bit select picks external reset source
// - Enabled edge clears counter on timer tick
// - Rise and fall clear enables independent
// - External clear gives no match, no postscale
// - Unscaled match goes only to output generator
// - Sleep stops timer, counter keeps value
// - Source map: ccp, cmp1, cmp2, flt, outs, zero
// - Divide select: 00 one, 01 four, 1x sixteen
// - Postscale value n flags every n+1 matches
// - Timer counts only while on bit set
//
// The implementer's own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module hardware_limit_timer
	import limit_timer_pkg::*;
(
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	// Processor state
	input wire logic i_sleep,
	// Peripheral reset sources, asynchronous to this clock
	input wire reset_src_s i_reset_src,
	// Avalon-MM slave
	input wire logic [4:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// Limit output to the complementary output generator
	output logic o_limit_match,
	// Match interrupt request to the processor
	output logic o_match_irq
);

	// ****************************************
	// Register bus slave
	// ****************************************
	logic wait_q; // Holds off every request for one cycle
	logic [31:0] rdata_q; // Read data captured with the answer
	logic wr_acc; // Write takes effect this edge
	logic wr_count; // Write to counter register
	logic wr_period; // Write to period register
	logic wr_ctrl0; // Write to first control register
	logic wr_ctrl1; // Write to second control register
	logic wr_flags; // Write to flag register
	logic wr_enables; // Write to enable register
	logic [31:0] rd_mux; // Selected read value

	logic [7:0] count_q; // limit_count
	logic [7:0] period_q; // limit_period
	ctrl_reg0_s ctrl0_q;
	ctrl_reg1_s ctrl1_q;
	logic match_irq_flag_q;
	logic match_irq_en_q;
	logic [3:0] post_q; // Postscale counter

	assign wr_acc = i_avs_write && !wait_q;
	assign wr_count = wr_acc && (i_avs_address == OFS_LIMIT_COUNT);
	assign wr_period = wr_acc && (i_avs_address == OFS_LIMIT_PERIOD);
	assign wr_ctrl0 = wr_acc && (i_avs_address == OFS_CTRL_REG0);
	assign wr_ctrl1 = wr_acc && (i_avs_address == OFS_CTRL_REG1);
	assign wr_flags = wr_acc && (i_avs_address == OFS_IRQ_FLAGS);
	assign wr_enables = wr_acc && (i_avs_address == OFS_IRQ_ENABLES);

	// Read multiplexer; unmapped addresses read zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (i_avs_address)
			OFS_LIMIT_COUNT: rd_mux[7:0] = count_q;
			OFS_LIMIT_PERIOD: rd_mux[7:0] = period_q;
			OFS_CTRL_REG0: rd_mux[6:0] = ctrl0_q;
			OFS_CTRL_REG1: rd_mux[4:0] = ctrl1_q;
			OFS_IRQ_FLAGS: rd_mux[IRQ_MATCH_BIT] = match_irq_flag_q;
			OFS_IRQ_ENABLES: rd_mux[IRQ_MATCH_BIT] = match_irq_en_q;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Answer every request one cycle after it appears
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wait_q <= 1'b1;
		end else if ((i_avs_read || i_avs_write) && wait_q) begin
			wait_q <= 1'b0;
		end else begin
			wait_q <= 1'b1;
		end
	end

	// Read data is loaded together with the answer
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rdata_q <= 32'h0000_0000;
		end else if (i_avs_read && wait_q) begin
			rdata_q <= rd_mux;
		end
	end

	assign o_avs_waitrequest = wait_q;
	assign o_avs_readdata = rdata_q;

	// ****************************************
	// Control registers
	// ****************************************
	// Period register: all ones after reset
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			period_q <= PERIOD_RESET;
		end else if (wr_period) begin
			period_q <= i_avs_writedata[7:0];
		end
	end

	// Control registers; the timer stays off after reset
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ctrl0_q <= '0;
			ctrl1_q <= '0;
		end else begin
			if (wr_ctrl0) begin
				ctrl0_q <= i_avs_writedata[6:0];
			end
			if (wr_ctrl1) begin
				ctrl1_q <= i_avs_writedata[4:0];
			end
		end
	end

	// Interrupt enable
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			match_irq_en_q <= 1'b0;
		end else if (wr_enables) begin
			match_irq_en_q <= i_avs_writedata[IRQ_MATCH_BIT];
		end
	end

	// ****************************************
	// Clock enables
	// ****************************************
	logic [1:0] instr_q; // Reference divider for the instruction clock
	logic instr_tick; // One pulse per instruction cycle
	logic run; // Timer is on and the processor awake
	logic [3:0] pre_q; // Prescale counter
	logic tick; // Timer clock rising edge
	logic scaler_clr; // Clears prescaler and postscaler

	assign run = ctrl0_q.timer_on && !i_sleep;
	assign instr_tick = (instr_q == INSTR_LAST);
	assign scaler_clr = wr_count || wr_ctrl0;

	// Free running divide by four of the reference clock
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			instr_q <= 2'h0;
		end else begin
			instr_q <= instr_q + 2'h1;
		end
	end

	// Prescale counter advances each instruction cycle while running
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pre_q <= 4'h0;
		end else if (scaler_clr) begin
			pre_q <= 4'h0;
		end else if (run && instr_tick) begin
			pre_q <= pre_q + 4'h1;
		end
	end

	// Timer tick selection from the prescale counter
	always_comb begin
		tick = 1'b0;
		if (run && instr_tick && !scaler_clr) begin
			if (ctrl0_q.clk_div_sel == DIV_SEL_1) begin
				tick = 1'b1;
			end else if (ctrl0_q.clk_div_sel == DIV_SEL_4) begin
				tick = (pre_q[1:0] == PRE_LAST_DIV4[1:0]);
			end else begin
				tick = (pre_q == PRE_LAST_DIV16);
			end
		end
	end

	// ****************************************
	// External reset source
	// ****************************************
	reset_src_s src_meta_q; // First synchroniser stage
	reset_src_s src_sync_q; // Second synchroniser stage
	logic src_sel; // Selected source level
	logic src_prev_q; // Level seen at the previous timer tick
	logic ext_clr; // Enabled edge seen at this tick

	// Comparators and other peripherals run off other timing, so synchronise
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			src_meta_q <= '0;
			src_sync_q <= '0;
		end else begin
			src_meta_q <= i_reset_src;
			src_sync_q <= src_meta_q;
		end
	end

	// Source selector; reserved positions read as zero
	always_comb begin
		case (ctrl1_q.reset_source_sel)
			SRC_CAPCMP: src_sel = src_sync_q.capture_compare;
			SRC_CMP1: src_sel = src_sync_q.comparator1_out;
			SRC_CMP2: src_sel = src_sync_q.comparator2_out;
			SRC_GEN_FAULT: src_sel = src_sync_q.gen_fault;
			SRC_GEN_OUT0: src_sel = src_sync_q.gen_out0;
			SRC_GEN_OUT1: src_sel = src_sync_q.gen_out1;
			default: src_sel = 1'b0;
		endcase
	end

	// Previous sample taken on timer ticks only
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			src_prev_q <= 1'b0;
		end else if (tick) begin
			src_prev_q <= src_sel;
		end
	end

	// A pulse shorter than one timer clock may be missed; the period must be long
	assign ext_clr = tick && ((ctrl1_q.rise_reset_en && src_sel && !src_prev_q) ||
		(ctrl1_q.fall_reset_en && !src_sel && src_prev_q));

	// ****************************************
	// Counter, match and postscaler
	// ****************************************
	logic match; // Count equals period
	logic match_adv; // Match consumed at this tick

	// Match and clear together set the period of period plus one ticks
	assign match = (count_q == period_q);
	assign match_adv = tick && match && !ext_clr;

	// Counter: the external clear takes priority over the match
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			count_q <= COUNT_RESET;
		end else if (wr_count) begin
			count_q <= i_avs_writedata[7:0];
		end else if (ext_clr) begin
			count_q <= COUNT_RESET;
		end else if (match_adv) begin
			count_q <= COUNT_RESET;
		end else if (tick) begin
			count_q <= count_q + 8'h01;
		end
	end

	// Postscaler counts consumed matches
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			post_q <= 4'h0;
		end else if (scaler_clr) begin
			post_q <= 4'h0;
		end else if (match_adv) begin
			if (post_q == ctrl0_q.postscale_sel) begin
				post_q <= 4'h0;
			end else begin
				post_q <= post_q + 4'h1;
			end
		end
	end

	// Sticky flag; a new overflow wins over a software clear
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			match_irq_flag_q <= 1'b0;
		end else if (match_adv && (post_q == ctrl0_q.postscale_sel)) begin
			match_irq_flag_q <= 1'b1;
		end else if (wr_flags && i_avs_writedata[IRQ_MATCH_BIT]) begin
			match_irq_flag_q <= 1'b0;
		end
	end

	// Outputs registered; limit is held while equal and running
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_limit_match <= 1'b0;
			o_match_irq <= 1'b0;
		end else begin
			o_limit_match <= match && run;
			o_match_irq <= match_irq_flag_q && match_irq_en_q;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	sequence s_match_tick;
		match_adv && !wr_count;
	endsequence

	sequence s_ext_tick;
		ext_clr && !wr_count;
	endsequence

	AST_MATCH_CLEARS: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		s_match_tick |=> (count_q == 8'h00))
		else $error("Counter not cleared after match");

	AST_EXT_CLEARS: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		s_ext_tick |=> (count_q == 8'h00))
		else $error("Counter not cleared by external edge");

	AST_EXT_NO_POST: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(ext_clr && !scaler_clr) |=> $stable(post_q))
		else $error("External clear advanced postscaler");

	AST_LIMIT_LEVEL: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(run && count_q == period_q) |=> o_limit_match)
		else $error("Limit output missing while equal");

	AST_OFF_HOLDS: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(!run && !wr_count) |=> $stable(count_q))
		else $error("Counter moved while stopped");

	AST_CTRL_KEEPS_COUNT: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(wr_ctrl0 && !wr_count) |=> (pre_q == 4'h0) && (post_q == 4'h0)
		&& (count_q == $past(count_q)))
		else $error("Control write handling wrong");

	AST_IRQ_GATED: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		o_match_irq |-> $past(match_irq_flag_q) && $past(match_irq_en_q))
		else $error("Interrupt without flag and enable");

	AST_FLAG_SET: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(match_adv && post_q == ctrl0_q.postscale_sel) |=> match_irq_flag_q)
		else $error("Flag not set on postscale overflow");

	AST_DIV1_RATE: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(tick && ctrl0_q.clk_div_sel == DIV_SEL_1) |-> ##4 (tick || !run || scaler_clr
		|| (ctrl0_q.clk_div_sel != DIV_SEL_1) || $changed(ctrl0_q)))
		else $error("Undivided timer tick not every four cycles");

	AST_BUS_ANSWER: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		((i_avs_read || i_avs_write) && wait_q) |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
		else $error("Bus answer not one cycle long");

	// Only a software write of one may drop the flag
	AST_FLAG_STICKY: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(match_irq_flag_q && !(wr_flags && i_avs_writedata[IRQ_MATCH_BIT]))
		|=> match_irq_flag_q)
		else $error("Match flag dropped without a clear");

	// Sleep freezes the count, prescale and postscale counters unless software writes count or control
	AST_SLEEP_FREEZE: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(i_sleep && !scaler_clr) |=> $stable(count_q) && $stable(pre_q)
		&& $stable(post_q))
		else $error("Timer moved during sleep");

	// A consumed match below the ratio advances the postscaler by one
	AST_POST_STEP: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
		(match_adv && post_q != ctrl0_q.postscale_sel)
		|=> (post_q == $past(post_q) + 4'h1))
		else $error("Postscaler did not step on match");

endmodule // hardware_limit_timer
`default_nettype wire

//--- verif/reset_src_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Peripheral reset source stand-in
// ****************************************
module reset_src_model
	import limit_timer_pkg::*;
#(
	parameter int HALF = 40 // Source half period; the limit period stays above it
)(
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	// Control from the bench
	input wire logic i_run,
	input wire logic [2:0] i_sel,
	// Source levels towards the timer
	output reset_src_s o_src
);
	logic [7:0] cnt_q; // Cycles since last edge
	logic lvl_q; // Level of the active source

	// Only the chosen source moves, so a wrong select shows up as a missed clear
	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cnt_q <= 8'h00;
			lvl_q <= 1'b0;
		end else if (!i_run) begin
			cnt_q <= 8'h00;
			lvl_q <= 1'b0;
		end else if (cnt_q == 8'(HALF - 1)) begin
			cnt_q <= 8'h00;
			lvl_q <= ~lvl_q;
		end else begin
			cnt_q <= cnt_q + 8'h01;
		end
	end

	// Selects 6 and 7 shift out of range and read as zero
	assign o_src = reset_src_s'(6'(lvl_q) << i_sel);
endmodule // reset_src_model
`default_nettype wire

//--- verif/hardware_limit_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module hardware_limit_timer_tb;
	import limit_timer_pkg::*;
	// ****************************************
	// Signals
	// ****************************************
	logic i_ref_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic i_sleep = 1'b0;
	reset_src_s i_reset_src;
	logic [4:0] i_avs_address = 5'h00;
	logic i_avs_read = 1'b0;
	logic i_avs_write = 1'b0;
	logic [31:0] i_avs_writedata = 32'h0;
	logic [31:0] o_avs_readdata;
	logic o_avs_waitrequest;
	logic o_limit_match;
	logic o_match_irq;
	logic src_run = 1'b0; // Partner toggles its source while high
	logic [2:0] src_sel = 3'h0;
	logic [31:0] rd; // Last read data
	int mismatches = 0;
	int n_checks = 0;
	int n;
	int i;
	// Period rows: divide select, period, cycles between limit rises
	logic [1:0] r_div [4] = '{DIV_SEL_1, DIV_SEL_4, 2'h2, 2'h3};
	logic [7:0] r_per [4] = '{8'h03, 8'h02, 8'h01, 8'h01};
	int r_gap [4] = '{16, 48, 128, 128};
	// Register rows: address, write data, expected read back
	logic [4:0] w_adr [6] = '{5'h00, 5'h04, 5'h0c, 5'h14, 5'h18, 5'h08};
	logic [31:0] w_dat [6] = '{32'h5a, 32'h1c3, 32'hff, 32'hff, 32'hff, 32'h83};
	logic [31:0] w_exp [6] = '{32'h5a, 32'hc3, 32'h1f, 32'h01, 32'h00, 32'h03};
	logic [31:0] post [3] = '{32'h0, 32'h2, 32'hf};

	always #2.5 i_ref_clk = ~i_ref_clk;

	hardware_limit_timer dut_u (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_sleep(i_sleep),
		.i_reset_src(i_reset_src), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
		.i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
		.o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
		.o_limit_match(o_limit_match), .o_match_irq(o_match_irq));

	reset_src_model src_u (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_run(src_run),
		.i_sel(src_sel), .o_src(i_reset_src));

	// ****************************************
	// Tasks
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		$display("checks=%0d mismatches=%0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// One bus cycle, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [4:0] adr, input logic [31:0] wd);
		int k;
		@(posedge i_ref_clk);
		i_avs_address <= adr;
		i_avs_writedata <= wd;
		i_avs_write <= wr;
		i_avs_read <= ~wr;
		for (k = 0; k < 50; k++) begin
			@(posedge i_ref_clk);
			if (o_avs_waitrequest === 1'b0) break;
		end
		rd = o_avs_readdata;
		i_avs_write <= 1'b0;
		i_avs_read <= 1'b0;
		if (k == 50) begin
			mismatches++;
			give_verdict();
		end
	endtask

	// Cycles until the next rise of the limit output; lim+1 if none
	task automatic wait_rise(input int lim, output int cnt);
		logic prev;
		prev = o_limit_match;
		for (cnt = 1; cnt <= lim; cnt++) begin
			@(posedge i_ref_clk);
			if (o_limit_match === 1'b1 && prev !== 1'b1) break;
			prev = o_limit_match;
		end
	endtask

	// Limit rises seen before the interrupt comes up, bounded
	task automatic count_rises(output int cnt);
		int c;
		logic prev;
		cnt = 0;
		prev = o_limit_match;
		for (c = 0; c < 400 && o_match_irq !== 1'b1; c++) begin
			@(posedge i_ref_clk);
			if (o_limit_match === 1'b1 && prev !== 1'b1) cnt++;
			prev = o_limit_match;
		end
		if (o_match_irq !== 1'b1) begin
			mismatches++;
			give_verdict();
		end
	endtask

	// Count clear, period all ones, the rest zero; also an unmapped word
	task automatic chk_reset();
		for (int a = 0; a < 7; a++) begin
			bus(1'b0, 5'(a * 4), 32'h0);
			check(rd, (a == 1) ? 32'hff : 32'h0);
		end
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (4) @(posedge i_ref_clk);
		i_resetn <= 1'b1;
		chk_reset();
		// Plain read and write of every register but the flags, timer left off
		for (i = 0; i < 6; i++) begin
			bus(1'b1, w_adr[i], w_dat[i]);
			bus(1'b0, w_adr[i], 32'h0);
			check(rd, w_exp[i]);
		end
		// Control write keeps the count
		bus(1'b1, OFS_CTRL_REG0, 32'h01);
		bus(1'b0, OFS_LIMIT_COUNT, 32'h0);
		check(rd, 32'h5a);
		bus(1'b1, OFS_CTRL_REG1, 32'h0);
		// Match spacing for each divide select
		for (i = 0; i < 4; i++) begin
			bus(1'b1, OFS_LIMIT_PERIOD, 32'(r_per[i]));
			bus(1'b1, OFS_LIMIT_COUNT, 32'h0);
			bus(1'b1, OFS_CTRL_REG0, 32'h4 | 32'(r_div[i]));
			wait_rise(600, n);
			wait_rise(600, n);
			check(n, r_gap[i]);
		end
		// Postscale ratios, then masking
		bus(1'b1, OFS_IRQ_ENABLES, 32'h1);
		for (i = 0; i < 3; i++) begin
			bus(1'b1, OFS_CTRL_REG0, 32'h0);
			bus(1'b1, OFS_IRQ_FLAGS, 32'h1);
			bus(1'b1, OFS_CTRL_REG0, (post[i] << 3) | 32'h4);
			count_rises(n);
			check(n, post[i] + 1);
		end
		bus(1'b1, OFS_IRQ_ENABLES, 32'h0);
		bus(1'b0, OFS_IRQ_FLAGS, 32'h0);
		check(rd, 32'h1);
		check(o_match_irq, 1'b0);
		// Sleep and off both freeze the count and hold the limit output low
		for (i = 0; i < 2; i++) begin
			i_sleep <= (i == 0);
			bus(1'b1, OFS_CTRL_REG0, (i == 0) ? 32'h4 : 32'h0);
			bus(1'b0, OFS_LIMIT_COUNT, 32'h0);
			n = int'(rd);
			repeat (40) @(posedge i_ref_clk);
			bus(1'b0, OFS_LIMIT_COUNT, 32'h0);
			check(rd, n);
			check(o_limit_match, 1'b0);
		end
		i_sleep <= 1'b0;
		// Source clears; rows 6 and 8 must reach the limit, 7 and 9 use one edge only
		bus(1'b1, OFS_LIMIT_PERIOD, 32'h20);
		bus(1'b1, OFS_LIMIT_COUNT, 32'h0);
		bus(1'b1, OFS_IRQ_FLAGS, 32'h1);
		bus(1'b1, OFS_CTRL_REG1, 32'h3);
		src_run <= 1'b1;
		bus(1'b1, OFS_CTRL_REG0, 32'h4);
		for (i = 0; i < 10; i++) begin
			if (i == 6) begin
				bus(1'b0, OFS_IRQ_FLAGS, 32'h0);
				check(rd, 32'h0);
			end
			src_sel <= (i >= 7) ? 3'h1 : 3'(i);
			bus(1'b1, OFS_CTRL_REG1, {27'h0, (i >= 7) ? 3'h1 : 3'(i),
				(i == 8) ? 2'h0 : ((i == 7) ? 2'h1 : ((i == 9) ? 2'h2 : 2'h3))});
			wait_rise(600, n);
			check(n > 600, !(i == 6 || i == 8));
		end
		// Second reset in mid-run
		@(posedge i_ref_clk);
		i_resetn <= 1'b0;
		repeat (4) @(posedge i_ref_clk);
		i_resetn <= 1'b1;
		chk_reset();
		give_verdict();
	end
endmodule // hardware_limit_timer_tb
`default_nettype wire
